// ==== hw/rxf_pkg.sv ====
// Constants for the receive address filter: register offsets, field
// positions, reset values and frame byte positions.
// Assumes a byte-wide host register port and a byte-wide receive stream.
//
// Functional notes
// - Unicast hit needs all six station bytes equal.
// - Station byte n holds destination bits 8n+7..8n.
// - CRC32 over address; latch six MSBs.
// - One-of-64 decode; multicast hit if bit set.
// - Hash byte k holds filter bits 8k+7..8k.
// - First received address bit one means multicast.
// - Broadcast hit needs all address bytes FF.
// - Frame bytes 12,13 must match VLAN tag.
// - A VLAN tag of zero in all 16 bits always passes.
// - VLAN filtering raises maximum length to 1522.
// - Aggregate combines hits with configuration bits.
package rxf_pkg;
   // Page 0 register offsets.
   localparam logic [4:0] RXF_RX_CONFIG_OFS = 5'h0c;
   localparam logic [4:0] RXF_MAC_CONFIG_OFS = 5'h1b;
   localparam logic [4:0] RXF_VLAN_LOW_OFS = 5'h1c;
   localparam logic [4:0] RXF_VLAN_HIGH_OFS = 5'h1d;
   // Page 1 offsets of the station and hash byte groups.
   localparam logic [4:0] RXF_STATION_OFS = 5'h01;
   localparam logic [4:0] RXF_HASH_OFS = 5'h08;
   // Field positions.
   localparam int RXF_ACCEPT_BCAST_BIT = 2;
   localparam int RXF_ACCEPT_MCAST_BIT = 3;
   localparam int RXF_PROMISC_BIT = 4;
   localparam int RXF_VLAN_EN_BIT = 0;
   // Reset value of every register.
   localparam logic [7:0] RXF_REG_RESET = 8'h00;
   // Frame byte positions, counted from zero.
   localparam logic [3:0] RXF_LAST_ADDR_IDX = 4'h5;
   localparam logic [3:0] RXF_TAG_HIGH_IDX = 4'hc;
   localparam logic [3:0] RXF_TAG_LOW_IDX = 4'hd;
   // CRC generator.
   localparam logic [31:0] RXF_CRC_INIT = 32'hffffffff;
   localparam logic [31:0] RXF_CRC_POLY = 32'h04c11db7;
   // Good frame length limits in bytes.
   localparam logic [10:0] RXF_MAX_LEN_PLAIN = 11'd1518;
   localparam logic [10:0] RXF_MAX_LEN_VLAN = 11'd1522;
   typedef enum logic {RXF_IDLE, RXF_RUN} rxf_state_type;
endpackage : rxf_pkg

// ==== hw/rxf_address_filter.sv ====
// Receive address filter: unicast, hashed multicast, broadcast and VLAN
// checks folded into one accept decision per frame.
// Assumes frame bytes arrive synchronous to clock, rxSof marking byte 0.
`timescale 1ns/1ns
`default_nettype none
module rxf_address_filter
   import rxf_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        resetn,
   input  wire logic        regPage,
   input  wire logic [4:0]  regAddr,
   input  wire logic        regWrite,
   input  wire logic        regRead,
   input  wire logic [7:0]  regWdata,
   output logic      [7:0]  regRdata,
   input  wire logic        rxValid,
   input  wire logic        rxSof,
   input  wire logic [7:0]  rxData,
   output logic             filterDone,
   output logic             aggregateHit,
   output logic             unicastHit,
   output logic             multicastHit,
   output logic             broadcastHit,
   output logic             vlanHit,
   output logic      [5:0]  hashIndex,
   output logic      [10:0] maxFrameLen
);
   logic [7:0]    stationAddr_q [6];
   logic [7:0]    hashFilterBytes_q [8];
   logic [7:0]    rxConfig_q;
   logic [7:0]    macConfig_q;
   logic [7:0]    vlanTagLow_q;
   logic [7:0]    vlanTagHigh_q;
   logic [63:0]   hashFilterBits;
   rxf_state_type state_q;
   logic [3:0]    byteCnt_q;
   logic [3:0]    byteIdx;
   logic          byteTaken;
   logic [47:0]   destAddr_q;
   logic          uniRun_q;
   logic          bcastRun_q;
   logic          mcastHit_q;
   logic [5:0]    hash_q;
   logic [31:0]   crc_q;
   logic [31:0]   crc_d;
   logic [7:0]    tagHigh_q;
   logic [15:0]   frameTag;
   logic          vlanOk;
   logic          uniFinal;
   logic          bcastFinal;
   logic          vlanEnable;

   // Bit-serial CRC over one byte, least significant bit first.
   function automatic logic [31:0] crcByte(input logic [31:0] c, input logic [7:0] d);
      logic [31:0] r;
      r = c;
      for (int i = 0; i < 8; i++)
      begin
         r = r[31] ^ d[i] ? {r[30:0], 1'b0} ^ RXF_CRC_POLY : {r[30:0], 1'b0};
      end
      return r;
   endfunction : crcByte

   // Host register writes; software owns every setting.
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         for (int i = 0; i < 6; i++)
            stationAddr_q[i] <= RXF_REG_RESET;
         for (int i = 0; i < 8; i++)
            hashFilterBytes_q[i] <= RXF_REG_RESET;
         rxConfig_q    <= RXF_REG_RESET;
         macConfig_q   <= RXF_REG_RESET;
         vlanTagLow_q  <= RXF_REG_RESET;
         vlanTagHigh_q <= RXF_REG_RESET;
      end
      else if (regWrite)
      begin
         if (regPage)
         begin
            for (int i = 0; i < 6; i++)
               if (regAddr == RXF_STATION_OFS + 5'(i))
                  stationAddr_q[i] <= regWdata;
            for (int i = 0; i < 8; i++)
               if (regAddr == RXF_HASH_OFS + 5'(i))
                  hashFilterBytes_q[i] <= regWdata;
         end
         else
         begin
            unique case (regAddr)
               RXF_RX_CONFIG_OFS:  rxConfig_q    <= regWdata;
               RXF_MAC_CONFIG_OFS: macConfig_q   <= regWdata;
               RXF_VLAN_LOW_OFS:   vlanTagLow_q  <= regWdata;
               RXF_VLAN_HIGH_OFS:  vlanTagHigh_q <= regWdata;
               default: ;
            endcase
         end
      end
   end

   // Read data is registered; unmapped offsets read zero.
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
         regRdata <= 8'h00;
      else if (regRead)
      begin
         regRdata <= 8'h00;
         if (regPage)
         begin
            for (int i = 0; i < 6; i++)
               if (regAddr == RXF_STATION_OFS + 5'(i))
                  regRdata <= stationAddr_q[i];
            for (int i = 0; i < 8; i++)
               if (regAddr == RXF_HASH_OFS + 5'(i))
                  regRdata <= hashFilterBytes_q[i];
         end
         else
         begin
            unique case (regAddr)
               RXF_RX_CONFIG_OFS:  regRdata <= rxConfig_q;
               RXF_MAC_CONFIG_OFS: regRdata <= macConfig_q;
               RXF_VLAN_LOW_OFS:   regRdata <= vlanTagLow_q;
               RXF_VLAN_HIGH_OFS:  regRdata <= vlanTagHigh_q;
               default:            regRdata <= 8'h00;
            endcase
         end
      end
   end

   always_comb
   begin
      for (int k = 0; k < 8; k++)
         hashFilterBits[8*k +: 8] = hashFilterBytes_q[k];
   end

   // Byte position tracking; a new start of frame always restarts.
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         state_q   <= RXF_IDLE;
         byteCnt_q <= 4'h0;
      end
      else if (byteTaken)
      begin
         byteCnt_q <= byteIdx + 4'h1;
         state_q   <= byteIdx == RXF_TAG_LOW_IDX ? RXF_IDLE : RXF_RUN;
      end
   end

   assign byteIdx   = rxSof ? 4'h0 : byteCnt_q;
   assign byteTaken = rxValid && (rxSof || state_q == RXF_RUN);
   assign crc_d     = crcByte(byteIdx == 4'h0 ? RXF_CRC_INIT : crc_q, rxData);

   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
         destAddr_q <= 48'h0;
      else if (byteTaken && byteIdx <= RXF_LAST_ADDR_IDX)
         destAddr_q[8*byteIdx +: 8] <= rxData;
   end

   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         uniRun_q   <= 1'b0;
         bcastRun_q <= 1'b0;
      end
      else if (byteTaken && byteIdx <= RXF_LAST_ADDR_IDX)
      begin
         uniRun_q   <= (byteIdx == 4'h0 || uniRun_q)
                       && rxData == stationAddr_q[byteIdx[2:0]];
         bcastRun_q <= (byteIdx == 4'h0 || bcastRun_q) && rxData == 8'hff;
      end
   end

   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         crc_q      <= RXF_CRC_INIT;
         hash_q     <= 6'h00;
         mcastHit_q <= 1'b0;
      end
      else if (byteTaken && byteIdx <= RXF_LAST_ADDR_IDX)
      begin
         crc_q <= crc_d;
         if (byteIdx == RXF_LAST_ADDR_IDX)
         begin
            hash_q <= crc_d[31:26];
            mcastHit_q <= destAddr_q[0] && hashFilterBits[crc_d[31:26]];
         end
      end
   end

   // The high tag byte is held until its partner arrives.
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
         tagHigh_q <= 8'h00;
      else if (byteTaken && byteIdx == RXF_TAG_HIGH_IDX)
         tagHigh_q <= rxData;
   end

   assign frameTag   = {tagHigh_q, rxData};
   assign vlanEnable = macConfig_q[RXF_VLAN_EN_BIT];
   assign uniFinal   = uniRun_q;
   assign bcastFinal = bcastRun_q;
   assign vlanOk = frameTag == 16'h0000 || frameTag == {vlanTagHigh_q, vlanTagLow_q};

   // Decision is made as the last tag byte arrives, so a short frame
   // that never reaches it produces no decision at all.
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         filterDone   <= 1'b0;
         aggregateHit <= 1'b0;
         unicastHit   <= 1'b0;
         multicastHit <= 1'b0;
         broadcastHit <= 1'b0;
         vlanHit      <= 1'b0;
         hashIndex    <= 6'h00;
      end
      else
      begin
         filterDone <= byteTaken && byteIdx == RXF_TAG_LOW_IDX;
         if (byteTaken && byteIdx == RXF_TAG_LOW_IDX)
         begin
            unicastHit   <= uniFinal;
            multicastHit <= mcastHit_q;
            broadcastHit <= bcastFinal;
            vlanHit      <= vlanOk;
            hashIndex    <= hash_q;
            aggregateHit <= (rxConfig_q[RXF_PROMISC_BIT] || uniFinal
                             || (mcastHit_q && rxConfig_q[RXF_ACCEPT_MCAST_BIT])
                             || (bcastFinal && rxConfig_q[RXF_ACCEPT_BCAST_BIT]))
                            && (!vlanEnable || vlanOk);
         end
      end
   end

   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
         maxFrameLen <= RXF_MAX_LEN_PLAIN;
      else
         maxFrameLen <= vlanEnable ? RXF_MAX_LEN_VLAN : RXF_MAX_LEN_PLAIN;
   end

   // Assertions share one clock and reset.
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!resetn);

   a_unicast_compare: assert property (
      filterDone |-> unicastHit == (destAddr_q == {stationAddr_q[5], stationAddr_q[4],
         stationAddr_q[3], stationAddr_q[2], stationAddr_q[1], stationAddr_q[0]}))
      else $error("unicast hit disagrees with station address");
   a_first_byte_order: assert property (
      byteTaken && byteIdx == 4'h0 |=> destAddr_q[7:0] == $past(rxData))
      else $error("first address byte not in low bits");
   a_hash_latched: assert property (
      byteTaken && byteIdx == RXF_LAST_ADDR_IDX ##1 byteTaken [*8] ##1 filterDone
      |-> hashIndex == $past(hash_q))
      else $error("hash index not the latched value");
   a_hash_select: assert property (
      filterDone |-> multicastHit == (destAddr_q[0] && hashFilterBits[hashIndex]))
      else $error("multicast hit disagrees with filter bit");
   a_hash_layout: assert property (
      filterDone |-> multicastHit == (destAddr_q[0]
         && hashFilterBytes_q[hashIndex[5:3]][hashIndex[2:0]]))
      else $error("multicast hit disagrees with hash byte layout");
   a_mcast_first_bit: assert property (
      filterDone && multicastHit |-> destAddr_q[0])
      else $error("multicast hit without group bit");
   a_broadcast_ones: assert property (
      filterDone |-> broadcastHit == (&destAddr_q))
      else $error("broadcast hit disagrees with address");
   a_vlan_compare: assert property (
      byteTaken && byteIdx == RXF_TAG_LOW_IDX && frameTag != {vlanTagHigh_q, vlanTagLow_q}
      && frameTag != 16'h0000 |=> !vlanHit && !(aggregateHit && vlanEnable))
      else $error("mismatching tag not rejected");
   a_vlan_zero_pass: assert property (
      byteTaken && byteIdx == RXF_TAG_LOW_IDX && frameTag == 16'h0000 |=> vlanHit)
      else $error("zero tag not passed");
   a_max_length: assert property (
      $rose(vlanEnable) |=> maxFrameLen == RXF_MAX_LEN_VLAN)
      else $error("maximum length not raised");
   a_aggregate_promisc: assert property (
      byteTaken && byteIdx == RXF_TAG_LOW_IDX && rxConfig_q[RXF_PROMISC_BIT] && !vlanEnable
      |=> filterDone && aggregateHit)
      else $error("promiscuous frame not accepted");
   a_aggregate_reject: assert property (
      filterDone && !unicastHit && !$past(rxConfig_q[RXF_PROMISC_BIT])
      && !(multicastHit && $past(rxConfig_q[RXF_ACCEPT_MCAST_BIT]))
      && !(broadcastHit && $past(rxConfig_q[RXF_ACCEPT_BCAST_BIT])) |-> !aggregateHit)
      else $error("frame accepted with no cause");
endmodule : rxf_address_filter
`default_nettype wire

// ==== bench/rxf_mac_model.sv ====
// Receive MAC model: hands frame bytes to the address filter.
// Assumes the bench calls sendFrame and no one else drives these lines.
`timescale 1ns/1ns
`default_nettype none
module rxf_mac_model
(
   input  wire logic       clock,
   output logic            rxValid,
   output logic            rxSof,
   output logic      [7:0] rxData
);
   // Idle from time zero.
   initial
   begin
      rxValid = 1'b0;
      rxSof   = 1'b0;
      rxData  = 8'h00;
   end
   // Sends n bytes, with gap idle cycles between bytes; idle data is inverted
   // so that a stale byte can never be mistaken for a fresh one.
   task sendFrame(input logic [47:0] da, input logic [15:0] tag, input int n, input int gap);
      logic [7:0] b;
      for (int i = 0; i < n; i++)
      begin
         b = (i < 6) ? da[8*i+:8] : (i == 12) ? tag[15:8] : (i == 13) ? tag[7:0] : 8'h5a;
         @(posedge clock);
         #2;
         rxValid = 1'b1;
         rxSof   = (i == 0);
         rxData  = b;
         repeat ((i < n - 1) ? gap : 0)
         begin
            @(posedge clock);
            #2;
            rxValid = 1'b0;
            rxData  = ~b;
         end
      end
      @(posedge clock);
      #2;
      rxValid = 1'b0;
      rxSof   = 1'b0;
      rxData  = ~b;
   endtask : sendFrame
endmodule : rxf_mac_model
`default_nettype wire

// ==== bench/testbench.sv ====
// Self-checking bench for the receive address filter.
// Assumes the MAC model drives the frame lines; the bench owns the register port.
`timescale 1ns/1ns
`default_nettype none
module testbench;
   import rxf_pkg::*;
   typedef struct packed {
      logic [47:0] da;
      logic [15:0] tag;
      logic [7:0]  cfg;
      logic        ven;
      logic        u;
      logic        b;
      logic        v;
   } rxf_row_type;
   localparam logic [47:0] STA = 48'hba9876543210;
   localparam logic [47:0] MC  = 48'h665544332201;
   localparam logic [47:0] BC  = 48'hffffffffffff;
   logic        clock = 1'b0;
   logic        resetn = 1'b0;
   logic        regPage = 1'b0;
   logic [4:0]  regAddr = 5'h00;
   logic        regWrite = 1'b0;
   logic        regRead = 1'b0;
   logic [7:0]  regWdata = 8'h00;
   wire  [7:0]  regRdata;
   wire         rxValid, rxSof, filterDone, aggregateHit;
   wire         unicastHit, multicastHit, broadcastHit, vlanHit;
   wire  [7:0]  rxData;
   wire  [5:0]  hashIndex;
   wire  [10:0] maxFrameLen;
   int          n_mismatch = 0;
   int          cmp_count = 0;
   int          cycleCount = 0;
   logic [63:0] hashTbl = 64'h0;
   logic [5:0]  h;
   logic        m;
   logic        ea;
   logic [10:0] el;
   rxf_row_type row;
   rxf_row_type rows [13] = '{
      '{STA, 16'h0000, 8'h00, 1'b0, 1'b1, 1'b0, 1'b1},
      '{STA, 16'h1234, 8'h00, 1'b1, 1'b1, 1'b0, 1'b1},
      '{STA, 16'h1235, 8'h00, 1'b1, 1'b1, 1'b0, 1'b0},
      '{STA, 16'h1235, 8'h00, 1'b0, 1'b1, 1'b0, 1'b0},
      '{48'hbb9876543210, 16'h0000, 8'h00, 1'b0, 1'b0, 1'b0, 1'b1},
      '{48'hba9876543212, 16'h0000, 8'h00, 1'b0, 1'b0, 1'b0, 1'b1},
      '{BC, 16'h0000, 8'h04, 1'b0, 1'b0, 1'b1, 1'b1},
      '{BC, 16'h0000, 8'h00, 1'b0, 1'b0, 1'b1, 1'b1},
      '{MC, 16'h0000, 8'h08, 1'b0, 1'b0, 1'b0, 1'b1},
      '{MC, 16'h0000, 8'h00, 1'b0, 1'b0, 1'b0, 1'b1},
      '{48'h665544332203, 16'h0000, 8'h08, 1'b0, 1'b0, 1'b0, 1'b1},
      '{MC, 16'h0000, 8'h08, 1'b1, 1'b0, 1'b0, 1'b1},
      '{48'h000000000002, 16'h1235, 8'h10, 1'b1, 1'b0, 1'b0, 1'b0}};

   // Clock of 20 ns and a cycle ceiling against hangs.
   always #10 clock = ~clock;
   always @(posedge clock)
   begin
      cycleCount++;
      if (cycleCount == 3000)
      begin
         n_mismatch++;
         tally_and_finish();
      end
   end

   rxf_address_filter i_dut (.clock(clock), .resetn(resetn), .regPage(regPage),
      .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata),
      .regRdata(regRdata), .rxValid(rxValid), .rxSof(rxSof), .rxData(rxData),
      .filterDone(filterDone), .aggregateHit(aggregateHit), .unicastHit(unicastHit),
      .multicastHit(multicastHit), .broadcastHit(broadcastHit), .vlanHit(vlanHit),
      .hashIndex(hashIndex), .maxFrameLen(maxFrameLen));
   rxf_mac_model i_mac (.clock(clock), .rxValid(rxValid), .rxSof(rxSof), .rxData(rxData));

   // Reference hash: bits enter LSB first, MSB-shifting register, no final invert.
   function automatic logic [5:0] hashOf(input logic [47:0] da);
      logic [31:0] c;
      c = RXF_CRC_INIT;
      for (int i = 0; i < 48; i++)
         c = (c << 1) ^ ((c[31] ^ da[i]) ? RXF_CRC_POLY : 32'h0);
      return c[31:26];
   endfunction : hashOf

   task cmpVal(input logic [15:0] got, input logic [15:0] exp, input string what);
      cmp_count++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("BAD %0t %s got %h want %h", $time, what, got, exp);
      end
   endtask : cmpVal

   task cmpBit(input logic got, input logic exp, input string what);
      cmpVal({15'h0, got}, {15'h0, exp}, what);
   endtask : cmpBit

   task regWr(input logic pg, input logic [4:0] a, input logic [7:0] d);
      @(posedge clock);
      #2;
      regPage = pg;
      regAddr = a;
      regWdata = d;
      regWrite = 1'b1;
      @(posedge clock);
      #2;
      regWrite = 1'b0;
   endtask : regWr

   task regRd(input logic pg, input logic [4:0] a, input logic [7:0] exp);
      @(posedge clock);
      #2;
      regPage = pg;
      regAddr = a;
      regRead = 1'b1;
      @(posedge clock);
      #2;
      regRead = 1'b0;
      cmpVal({8'h00, regRdata}, {8'h00, exp}, "register");
   endtask : regRd

   task tally_and_finish();
      $display("mismatches %0d, comparisons %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : tally_and_finish

   // Main sequence: reset values, set-up, the row loop, then the awkward cases.
   initial
   begin
      repeat (6) @(posedge clock);
      #2;
      resetn = 1'b1;
      cmpVal({5'h0, maxFrameLen}, {5'h0, RXF_MAX_LEN_PLAIN}, "len");
      for (int a = 0; a < 16; a++)
         regRd(1'b1, 5'(a), RXF_REG_RESET);
      regWr(1'b0, 5'h00, 8'hff);
      regRd(1'b0, 5'h00, 8'h00);
      regRd(1'b0, RXF_VLAN_HIGH_OFS, RXF_REG_RESET);
      for (int k = 0; k < 6; k++)
         regWr(1'b1, 5'(RXF_STATION_OFS + k), STA[8*k+:8]);
      regRd(1'b1, 5'(RXF_STATION_OFS + 5), STA[47:40]);
      regWr(1'b0, RXF_VLAN_HIGH_OFS, 8'h12);
      regWr(1'b0, RXF_VLAN_LOW_OFS, 8'h34);
      h = hashOf(MC);
      hashTbl[h] = 1'b1;
      regWr(1'b1, 5'(RXF_HASH_OFS + h[5:3]), 8'h01 << h[2:0]);
      regRd(1'b1, 5'(RXF_HASH_OFS + h[5:3]), 8'h01 << h[2:0]);
      for (int r = 0; r < 13; r++)
      begin
         row = rows[r];
         regWr(1'b0, RXF_RX_CONFIG_OFS, row.cfg);
         regWr(1'b0, RXF_MAC_CONFIG_OFS, {7'h00, row.ven});
         i_mac.sendFrame(row.da, row.tag, 14, 0);
         m = row.da[0] & hashTbl[hashOf(row.da)];
         cmpBit(filterDone, 1'b1, "done");
         cmpBit(unicastHit, row.u, "uni");
         cmpBit(broadcastHit, row.b, "bro");
         cmpBit(multicastHit, m, "mul");
         cmpBit(vlanHit, row.v, "vlan");
         cmpVal({10'h0, hashIndex}, {10'h0, hashOf(row.da)}, "hash");
         el = row.ven ? RXF_MAX_LEN_VLAN : RXF_MAX_LEN_PLAIN;
         ea = (row.cfg[RXF_PROMISC_BIT] | row.u | (m & row.cfg[RXF_ACCEPT_MCAST_BIT])
            | (row.b & row.cfg[RXF_ACCEPT_BCAST_BIT])) & (!row.ven | row.v);
         cmpVal({5'h0, maxFrameLen}, {5'h0, el}, "len");
         cmpBit(aggregateHit, ea, "agg");
      end
      regRd(1'b0, RXF_RX_CONFIG_OFS, 8'h10);
      // A short frame cut by a new start, then a frame with gaps between bytes.
      i_mac.sendFrame(BC, 16'h0, 7, 0);
      cmpBit(filterDone, 1'b0, "short");
      i_mac.sendFrame(STA, 16'h1234, 14, 1);
      cmpBit(filterDone, 1'b1, "gap done");
      cmpBit(unicastHit, 1'b1, "gap uni");
      cmpBit(broadcastHit, 1'b0, "gap bro");
      // Reset between frames, with the filter idle, clears settings and results.
      @(posedge clock);
      #2;
      resetn = 1'b0;
      repeat (2) @(posedge clock);
      #2;
      resetn = 1'b1;
      cmpBit(aggregateHit, 1'b0, "reset agg");
      cmpVal({5'h0, maxFrameLen}, {5'h0, RXF_MAX_LEN_PLAIN}, "reset len");
      regRd(1'b0, RXF_RX_CONFIG_OFS, RXF_REG_RESET);
      tally_and_finish();
   end
endmodule : testbench
`default_nettype wire
